// ==== seg_xlat_pkg.sv ====
package seg_xlat_pkg;

  // Segment register file
  localparam int SEG_COUNT = 6;
  localparam logic [2:0] CODE_SEGMENT_REG = 3'h0;
  localparam logic [2:0] STACK_SEGMENT_REG = 3'h1;
  localparam logic [2:0] DATA_SEGMENT_REG = 3'h2;
  localparam logic [2:0] EXTRA_SEGMENT_REG = 3'h3;
  localparam logic [2:0] SECOND_EXTRA_SEGMENT_REG = 3'h4;
  localparam logic [2:0] THIRD_EXTRA_SEGMENT_REG = 3'h5;

  // Selector layout
  localparam int SEL_W = 16;
  localparam int SEL_PRIV_LSB = 0;
  localparam int SEL_TABLE_BIT = 2;
  localparam int SEL_INDEX_LSB = 3;
  localparam int SEL_INDEX_W = 13;
  localparam int DESC_ENTRIES = 8192;
  localparam int DESC_SIZE_SHIFT = 3;

  // Address widths
  localparam int OFS_W = 32;
  localparam int LIN_W = 32;
  localparam int PHYS_WIDE_W = 36;
  localparam int WIDE_PHYS_ENABLE_BIT = 5;

  // Descriptor field positions (64-bit descriptor)
  localparam int D_LIMIT_LO_LSB = 0;
  localparam int D_BASE_LO_LSB = 16;
  localparam int D_BASE_MID_LSB = 32;
  localparam int D_TYPE_LSB = 40;
  localparam int D_SYS_BIT = 44;
  localparam int D_PRIV_LSB = 45;
  localparam int D_PRESENT_BIT = 47;
  localparam int D_LIMIT_HI_LSB = 48;
  localparam int D_BIG_BIT = 54;
  localparam int D_GRAN_BIT = 55;
  localparam int D_BASE_HI_LSB = 56;

  // Type field bits
  localparam int T_EXEC_BIT = 3;
  localparam int T_DIR_BIT = 2;
  localparam int T_RW_BIT = 1;

  // Limit scaling
  localparam int GRAN_SHIFT = 12;
  localparam logic [31:0] SMALL_TOP = 32'h0000FFFF;

  // Cached (visible + hidden) segment register
  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [19:0] limit;
    logic gran;
    logic big;
    logic exec;
    logic dir;
    logic rw;
    logic code_data;
    logic [1:0] priv;
    logic present;
  } seg_s;

  // After reset: selector zero, base 0, 64 KB writable data
  localparam seg_s SEG_RESET = '{sel: 16'h0000, base: 32'h00000000, limit: 20'h0FFFF,
                                  gran: 1'b0, big: 1'b0, exec: 1'b0, dir: 1'b0, rw: 1'b1,
                                  code_data: 1'b1, priv: 2'h0, present: 1'b1};

  typedef enum logic [0:0] {ST_IDLE, ST_FETCH} fsm_e;

endpackage : seg_xlat_pkg

// ==== desc_unpack.sv ====
module desc_unpack
  import seg_xlat_pkg::*;
(
  // Raw descriptor
  input wire logic [63:0] desc,
  input wire logic [15:0] sel,
  // Cached form
  output seg_s seg
);

  logic [3:0] typ;

  assign typ = desc[D_TYPE_LSB +: 4];

  always_comb
  begin
    seg.sel = sel;
    seg.base = {desc[D_BASE_HI_LSB +: 8], desc[D_BASE_MID_LSB +: 8],
                desc[D_BASE_LO_LSB +: 16]};
    seg.limit = {desc[D_LIMIT_HI_LSB +: 4], desc[D_LIMIT_LO_LSB +: 16]};
    seg.gran = desc[D_GRAN_BIT];
    seg.big = desc[D_BIG_BIT];
    seg.exec = typ[T_EXEC_BIT];
    seg.dir = typ[T_DIR_BIT];
    seg.rw = typ[T_RW_BIT];
    seg.code_data = desc[D_SYS_BIT];
    seg.priv = desc[D_PRIV_LSB +: 2];
    seg.present = desc[D_PRESENT_BIT];
  end

endmodule : desc_unpack

// ==== limit_check.sv ====
module limit_check
  import seg_xlat_pkg::*;
(
  // Offset and cached limit
  input wire logic [31:0] offset,
  input wire logic [19:0] limit,
  input wire logic gran,
  input wire logic expand_down,
  input wire logic big,
  // Result
  output logic in_range
);

  logic [31:0] eff;
  logic [31:0] top;

  // page-granular limit ignores low twelve bits
  assign eff = gran ? {limit, 12'hFFF} : {12'h000, limit};
  assign top = big ? 32'hFFFFFFFF : SMALL_TOP;

  always_comb
  begin
    if (expand_down)
    begin
      in_range = (offset > eff) && (offset <= top);
    end
    else
    begin
      in_range = (offset <= eff);
    end
  end

endmodule : limit_check

// ==== segment_address_translation.sv ====
module segment_address_translation
  import seg_xlat_pkg::*;
#(
  parameter int PHYS_W = PHYS_WIDE_W
)
(
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Selector load from execution core
  input wire logic LOAD_REQ,
  input wire logic [2:0] LOAD_SEG,
  input wire logic [15:0] LOAD_SEL,
  input wire logic LOAD_IMPLIED,
  output logic LOAD_BUSY,
  output logic LOAD_DONE,
  output logic LOAD_GP,
  output logic LOAD_NP,
  // Descriptor fetch
  output logic DESC_REQ,
  output logic [31:0] DESC_ADDR,
  input wire logic DESC_ACK,
  input wire logic [63:0] DESC_DATA,
  // Table bases and control
  input wire logic [31:0] GLOBAL_TABLE_BASE_REG,
  input wire logic [31:0] LOCAL_TABLE_BASE_REG,
  input wire logic [31:0] CONTROL_REGISTER_FOUR,
  input wire logic PAGING_EN,
  // Memory reference
  input wire logic REF_REQ,
  input wire logic [2:0] REF_SEG,
  input wire logic [31:0] REF_OFFSET,
  input wire logic REF_WRITE,
  input wire logic REF_USER,
  output logic REF_GP,
  // Physical address out (paging off)
  output logic PHYS_VALID,
  output logic [PHYS_W-1:0] PHYS_ADDR,
  // Linear address to page stage (paging on)
  output logic PAGE_VALID,
  output logic [31:0] PAGE_LIN,
  output logic PAGE_WRITE,
  output logic PAGE_USER,
  output logic PAGE_WIDE,
  // Visible selector readout
  input wire logic [2:0] SEL_RD_SEG,
  output logic [15:0] SEL_RD_DATA
);

  // Narrower than 32 would cut linear addresses; wider than 36 has no meaning
  if (PHYS_W < LIN_W || PHYS_W > PHYS_WIDE_W)
  begin : g_width_chk
    $error("PHYS_W must lie between 32 and 36");
  end

  typedef struct packed {
    fsm_e fsm;
    seg_s [SEG_COUNT-1:0] seg;
    logic [2:0] ld_tgt;
    logic [15:0] ld_sel;
    logic load_done;
    logic load_gp;
    logic load_np;
    logic load_busy;
    logic desc_req;
    logic [31:0] desc_addr;
    logic ref_gp;
    logic phys_valid;
    logic [PHYS_W-1:0] phys_addr;
    logic page_valid;
    logic [31:0] page_lin;
    logic page_write;
    logic page_user;
    logic page_wide;
    logic [15:0] sel_rd;
  } state_s;

  localparam state_s ST_RESET = '{fsm: ST_IDLE, seg: {SEG_COUNT{SEG_RESET}}, default: '0};

  state_s r;
  state_s n;

  seg_s fetched;
  seg_s cur;
  logic cur_in_range;
  logic ref_seg_ok;
  logic [SEG_COUNT-1:0] seg_null;
  logic ref_type_bad;
  logic ref_bad;

  desc_unpack u_unpack (
    .desc(DESC_DATA),
    .sel(r.ld_sel),
    .seg(fetched)
  );

  // only the six cached registers are reachable
  assign ref_seg_ok = (REF_SEG < 3'(SEG_COUNT));
  // Index 6 or 7 reads a harmless default; ref_seg_ok raises the fault
  assign cur = ref_seg_ok ? r.seg[REF_SEG] : SEG_RESET;

  limit_check u_limit (
    .offset(REF_OFFSET),
    .limit(cur.limit),
    .gran(cur.gran),
    .expand_down(cur.dir & ~cur.exec),
    .big(cur.big),
    .in_range(cur_in_range)
  );

  function automatic logic is_null(input logic [15:0] sel);
    // index zero in the global table
    is_null = (sel[SEL_W-1:SEL_INDEX_LSB] == 13'h0000) && !sel[SEL_TABLE_BIT];
  endfunction : is_null

  // null flag decoded once per register
  for (genvar i = 0; i < SEG_COUNT; i++)
  begin : g_null
    assign seg_null[i] = is_null(r.seg[i].sel);
  end

  // rights and limit settled before the add
  always_comb
  begin
    if (REF_WRITE)
    begin
      // Code never writable; data only when marked so
      ref_type_bad = cur.exec || !cur.rw;
    end
    else
    begin
      // Execute-only code cannot be read
      ref_type_bad = cur.exec && !cur.rw;
    end
    ref_bad = !ref_seg_ok || !cur.present || !cur_in_range || ref_type_bad;
    // null visible selector faults on use
    if (ref_seg_ok && seg_null[REF_SEG])
    begin
      ref_bad = 1'b1;
    end
  end

  always_comb
  begin
    logic [2:0] tgt;
    logic [31:0] tbase;
    logic [31:0] lin;
    tgt = 3'h0;
    tbase = 32'h00000000;
    lin = 32'h00000000;
    n = r;
    n.load_done = 1'b0;
    n.ref_gp = 1'b0;
    n.phys_valid = 1'b0;
    n.page_valid = 1'b0;
    n.sel_rd = (SEL_RD_SEG < 3'(SEG_COUNT)) ? r.seg[SEL_RD_SEG].sel : 16'h0000;

    case (r.fsm)
      ST_IDLE:
      begin
        if (LOAD_REQ)
        begin
          // implied loads always target the code register
          tgt = LOAD_IMPLIED ? CODE_SEGMENT_REG : LOAD_SEG;
          n.ld_tgt = tgt;
          // privilege bits ride along in the stored selector
          n.ld_sel = LOAD_SEL;
          n.load_gp = 1'b0;
          n.load_np = 1'b0;
          if (tgt >= 3'(SEG_COUNT))
          begin
            n.load_done = 1'b1;
            n.load_gp = 1'b1;
          end
          else if (is_null(LOAD_SEL))
          begin
            n.load_done = 1'b1;
            // null into code or stack register
            if (tgt == CODE_SEGMENT_REG || tgt == STACK_SEGMENT_REG)
            begin
              n.load_gp = 1'b1;
            end
            else
            begin
              // null accepted silently, hidden part cleared
              n.seg[tgt] = '0;
              n.seg[tgt].sel = LOAD_SEL;
            end
          end
          else
          begin
            tbase = LOAD_SEL[SEL_TABLE_BIT] ? LOCAL_TABLE_BASE_REG : GLOBAL_TABLE_BASE_REG;
            // table base plus index times eight
            n.desc_addr = tbase + {16'h0000, LOAD_SEL[SEL_W-1:SEL_INDEX_LSB], 3'b000};
            n.desc_req = 1'b1;
            n.load_busy = 1'b1;
            n.fsm = ST_FETCH;
          end
        end
      end

      ST_FETCH:
      begin
        if (DESC_ACK)
        begin
          n.desc_req = 1'b0;
          n.load_busy = 1'b0;
          n.load_done = 1'b1;
          n.fsm = ST_IDLE;
          // A faulted load leaves the register untouched
          // System descriptors never load a segment register
          if (!fetched.code_data)
          begin
            n.load_gp = 1'b1;
          end
          else if (r.ld_tgt == STACK_SEGMENT_REG && (fetched.exec || !fetched.rw))
          begin
            n.load_gp = 1'b1;
          end
          else if (r.ld_tgt == CODE_SEGMENT_REG && !fetched.exec)
          begin
            n.load_gp = 1'b1;
          end
          else if (fetched.exec && !fetched.rw && r.ld_tgt != CODE_SEGMENT_REG)
          begin
            n.load_gp = 1'b1;
          end
          else if (!fetched.present)
          begin
            n.load_np = 1'b1;
          end
          else
          begin
            // cache base, limit and access in hidden part
            n.seg[r.ld_tgt] = fetched;
          end
        end
      end

      default:
      begin
        n.fsm = ST_IDLE;
        n.desc_req = 1'b0;
        n.load_busy = 1'b0;
      end
    endcase

    if (REF_REQ)
    begin
      // cached copy used even if the table changed
      lin = cur.base + REF_OFFSET;
      if (ref_bad)
      begin
        n.ref_gp = 1'b1;
      end
      else if (PAGING_EN)
      begin
        n.page_valid = 1'b1;
        n.page_lin = lin;
        // page stage gets write and user for page checks
        n.page_write = REF_WRITE;
        n.page_user = REF_USER;
        n.page_wide = CONTROL_REGISTER_FOUR[WIDE_PHYS_ENABLE_BIT];
      end
      else
      begin
        // unpaged: linear is physical, upper bits zero
        n.phys_valid = 1'b1;
        n.phys_addr = PHYS_W'(lin);
      end
    end
  end

  // CE low holds pulse outputs too, so they stretch
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      r <= ST_RESET;
    end
    else if (CE)
    begin
      r <= n;
    end
  end

  // Load handshake
  assign LOAD_BUSY = r.load_busy;
  assign LOAD_DONE = r.load_done;
  assign LOAD_GP = r.load_gp;
  assign LOAD_NP = r.load_np;

  // Descriptor fetch
  assign DESC_REQ = r.desc_req;
  assign DESC_ADDR = r.desc_addr;

  // Reference outcome
  assign REF_GP = r.ref_gp;
  assign PHYS_VALID = r.phys_valid;
  assign PHYS_ADDR = r.phys_addr;
  assign PAGE_VALID = r.page_valid;
  assign PAGE_LIN = r.page_lin;
  assign PAGE_WRITE = r.page_write;
  assign PAGE_USER = r.page_user;
  assign PAGE_WIDE = r.page_wide;

  // Selector readout
  assign SEL_RD_DATA = r.sel_rd;

endmodule : segment_address_translation

// ==== seg_xlat_chk_sva.sv ====
module seg_xlat_chk
  import seg_xlat_pkg::*;
#(
  parameter int PHYS_W = PHYS_WIDE_W
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Load side
  input wire logic LOAD_REQ,
  input wire logic [2:0] LOAD_SEG,
  input wire logic [15:0] LOAD_SEL,
  input wire logic LOAD_IMPLIED,
  input wire logic LOAD_BUSY,
  input wire logic LOAD_DONE,
  input wire logic LOAD_GP,
  input wire logic LOAD_NP,
  input wire logic DESC_REQ,
  input wire logic [31:0] DESC_ADDR,
  input wire logic DESC_ACK,
  input wire logic [31:0] GLOBAL_TABLE_BASE_REG,
  input wire logic [31:0] LOCAL_TABLE_BASE_REG,
  input wire logic [31:0] CONTROL_REGISTER_FOUR,
  input wire logic PAGING_EN,
  // Reference side
  input wire logic REF_REQ,
  input wire logic REF_WRITE,
  input wire logic REF_USER,
  input wire logic REF_GP,
  input wire logic PHYS_VALID,
  input wire logic [PHYS_W-1:0] PHYS_ADDR,
  input wire logic PAGE_VALID,
  input wire logic PAGE_WRITE,
  input wire logic PAGE_USER,
  input wire logic PAGE_WIDE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN || !CE);
  logic [31:0] exp_addr_r;
  // Table entry address captured when a load is taken
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      exp_addr_r <= 32'h0;
    else if (LOAD_REQ && !LOAD_BUSY && CE)
      exp_addr_r <= (LOAD_SEL[2] ? LOCAL_TABLE_BASE_REG : GLOBAL_TABLE_BASE_REG)
                    + {16'h0, LOAD_SEL[15:3], 3'h0};
  end
  a_ref_one_outcome: assert property (REF_REQ |=> $onehot({REF_GP, PHYS_VALID, PAGE_VALID}))
    else $error("reference gave no single outcome");
  a_ref_no_request: assert property (!REF_REQ |=> !(REF_GP || PHYS_VALID || PAGE_VALID))
    else $error("reference outcome without request");
  a_unpaged_route: assert property (REF_REQ && !PAGING_EN |=> !PAGE_VALID)
    else $error("page stage used with paging off");
  a_paged_route: assert property (REF_REQ && PAGING_EN |=> !PHYS_VALID)
    else $error("physical address issued with paging on");
  a_page_attrs: assert property (REF_REQ && PAGING_EN |=> !PAGE_VALID
    || (PAGE_WRITE == $past(REF_WRITE) && PAGE_USER == $past(REF_USER)))
    else $error("page stage attributes wrong");
  a_wide_forward: assert property (REF_REQ && PAGING_EN && CONTROL_REGISTER_FOUR[5]
    |=> !PAGE_VALID || PAGE_WIDE)
    else $error("wide enable not forwarded");
  a_phys_upper_zero: assert property (PHYS_VALID |-> PHYS_ADDR[PHYS_W-1:32] == '0)
    else $error("unpaged address above 32 bits");
  a_desc_addr: assert property ($rose(DESC_REQ) |-> DESC_ADDR == exp_addr_r)
    else $error("descriptor address wrong");
  a_null_load_fast: assert property (LOAD_REQ && !LOAD_BUSY && LOAD_SEL[15:2] == 14'h0
    && LOAD_SEG < 3'h6 |=> LOAD_DONE && !DESC_REQ && !LOAD_NP
    && LOAD_GP == ($past(LOAD_SEG) < 3'h2 || $past(LOAD_IMPLIED)))
    else $error("null selector load wrong");
  a_desc_hold: assert property (DESC_REQ && !DESC_ACK |=> DESC_REQ && $stable(DESC_ADDR))
    else $error("descriptor request dropped early");
  a_done_after_ack: assert property (DESC_REQ && DESC_ACK |=> LOAD_DONE && !DESC_REQ)
    else $error("load not finished after descriptor");
  a_busy_fetch: assert property (LOAD_BUSY == DESC_REQ)
    else $error("busy flag disagrees with descriptor request");
  a_fault_single: assert property (LOAD_DONE |-> !(LOAD_GP && LOAD_NP))
    else $error("load reported two fault kinds");
  c_ref_fault: cover property (REF_GP);
  c_paged: cover property (PAGE_VALID && PAGE_WIDE);
  c_absent: cover property (LOAD_DONE && LOAD_NP);
endmodule : seg_xlat_chk

// ==== desc_mem.sv ====
module desc_mem
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Descriptor fetch
  input wire logic DESC_REQ,
  input wire logic [31:0] DESC_ADDR,
  output logic DESC_ACK,
  output logic [63:0] DESC_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] tbl [logic [31:0]];
  int dly = 0;
  int cnt;
  // Idle data toggles so a stale word never looks like an answer
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DESC_ACK <= 1'b0;
      DESC_DATA <= 64'h0;
      cnt <= 0;
    end
    else if (DESC_REQ && !DESC_ACK && cnt >= dly)
    begin
      DESC_ACK <= 1'b1;
      DESC_DATA <= tbl.exists(DESC_ADDR) ? tbl[DESC_ADDR] : 64'h0;
      cnt <= 0;
    end
    else
    begin
      DESC_ACK <= 1'b0;
      DESC_DATA <= ~DESC_DATA;
      cnt <= DESC_REQ ? cnt + 1 : 0;
    end
  end
endmodule : desc_mem

// ==== segment_address_translation_tb_top.sv ====
module segment_address_translation_tb_top
  import seg_xlat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] GB = 32'h00010000;
  localparam logic [31:0] LB = 32'h00200000;
  logic CLK, RESETN, CE, LOAD_REQ, LOAD_IMPLIED, LOAD_BUSY, LOAD_DONE, LOAD_GP, LOAD_NP;
  logic DESC_REQ, DESC_ACK, PAGING_EN, REF_REQ, REF_WRITE, REF_USER, REF_GP, PHYS_VALID;
  logic PAGE_VALID, PAGE_WRITE, PAGE_USER, PAGE_WIDE;
  logic [2:0] LOAD_SEG, REF_SEG, SEL_RD_SEG;
  logic [15:0] LOAD_SEL, SEL_RD_DATA;
  logic [31:0] DESC_ADDR, GLOBAL_TABLE_BASE_REG, LOCAL_TABLE_BASE_REG, CONTROL_REGISTER_FOUR;
  logic [31:0] REF_OFFSET, PAGE_LIN;
  logic [63:0] DESC_DATA;
  logic [35:0] PHYS_ADDR;
  int failures = 0;
  int compares = 0;
  segment_address_translation dut_u (.CLK, .RESETN, .CE, .LOAD_REQ, .LOAD_SEG, .LOAD_SEL,
    .LOAD_IMPLIED, .LOAD_BUSY, .LOAD_DONE, .LOAD_GP, .LOAD_NP, .DESC_REQ, .DESC_ADDR,
    .DESC_ACK, .DESC_DATA, .GLOBAL_TABLE_BASE_REG, .LOCAL_TABLE_BASE_REG,
    .CONTROL_REGISTER_FOUR, .PAGING_EN, .REF_REQ, .REF_SEG, .REF_OFFSET, .REF_WRITE,
    .REF_USER, .REF_GP, .PHYS_VALID, .PHYS_ADDR, .PAGE_VALID, .PAGE_LIN, .PAGE_WRITE,
    .PAGE_USER, .PAGE_WIDE, .SEL_RD_SEG, .SEL_RD_DATA);
  desc_mem mem_u (.CLK, .RESETN, .DESC_REQ, .DESC_ADDR, .DESC_ACK, .DESC_DATA);
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  function automatic logic [63:0] mk(input logic [31:0] b, input logic [19:0] l,
                                     input logic [3:0] t, input logic p, input logic g);
    mk = {b[31:24], g, 2'b10, 1'b0, l[19:16], p, 2'b00, 1'b1, t, b[23:16], b[15:0], l[15:0]};
  endfunction : mk
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic load(input logic [2:0] sg, input logic [15:0] sl, input logic imp,
                      input logic [1:0] fault);
    int n;
    @(negedge CLK);
    LOAD_REQ = 1'b1;
    LOAD_SEG = sg;
    LOAD_SEL = sl;
    LOAD_IMPLIED = imp;
    @(negedge CLK);
    LOAD_REQ = 1'b0;
    n = 0;
    while (LOAD_DONE !== 1'b1 && n < 20)
    begin
      @(negedge CLK);
      n++;
    end
    if (n == 20)
    begin
      failures++;
      test_done();
    end
    else
      chk({LOAD_GP, LOAD_NP}, fault);
  endtask : load
  // Outcome code: 4 fault, 2 physical, 1 page stage
  task automatic xref(input logic [2:0] sg, input logic [31:0] ofs, input logic [2:0] kind,
                      input logic [35:0] adr);
    @(negedge CLK);
    REF_REQ = 1'b1;
    REF_SEG = sg;
    REF_OFFSET = ofs;
    @(negedge CLK);
    REF_REQ = 1'b0;
    chk({REF_GP, PHYS_VALID, PAGE_VALID}, kind);
    if (kind != 3'h4)
      chk(PAGING_EN ? {4'h0, PAGE_LIN} : PHYS_ADDR, adr);
  endtask : xref
  task automatic rd(input logic [2:0] sg, input logic [15:0] exp);
    @(negedge CLK);
    SEL_RD_SEG = sg;
    @(negedge CLK);
    chk(SEL_RD_DATA, exp);
  endtask : rd
  initial
  begin
    {RESETN, LOAD_REQ, LOAD_IMPLIED, PAGING_EN, REF_REQ, REF_WRITE, REF_USER} = 7'h0;
    CE = 1'b1;
    {LOAD_SEG, REF_SEG, SEL_RD_SEG} = 9'h0;
    LOAD_SEL = 16'h0;
    REF_OFFSET = 32'h0;
    CONTROL_REGISTER_FOUR = 32'h0;
    GLOBAL_TABLE_BASE_REG = GB;
    LOCAL_TABLE_BASE_REG = LB;
    mem_u.tbl[GB + 8] = mk(32'h12345678, 20'h00FFF, 4'h2, 1'b1, 1'b0);
    mem_u.tbl[LB + 16] = mk(32'h00400000, 20'h00000, 4'h2, 1'b1, 1'b1);
    mem_u.tbl[GB + 24] = mk(32'h0, 20'hFFFFF, 4'hA, 1'b1, 1'b1);
    mem_u.tbl[GB + 32] = mk(32'h0, 20'hFFFFF, 4'h2, 1'b0, 1'b1);
    mem_u.tbl[GB + 40] = mk(32'h0, 20'hFFFFF, 4'h0, 1'b1, 1'b1);
    mem_u.tbl[GB + 48] = mk(32'h00100000, 20'h00FFF, 4'h6, 1'b1, 1'b0);
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    RESETN = 1'b1;
    rd(3'h2, 16'h0);
    xref(3'h2, 32'h0, 3'h4, 36'h0);
    $display("Reset test done");
    for (int s = 0; s < 6; s++)
      load(s[2:0], 16'h0000, 1'b0, {s < 2, 1'b0});
    $display("Null selector test done");
    load(3'h2, 16'h0008, 1'b0, 2'h0);
    xref(3'h2, 32'h10, 3'h2, 36'h012345688);
    xref(3'h2, 32'hFFF, 3'h2, 36'h012346677);
    xref(3'h2, 32'h1000, 3'h4, 36'h0);
    rd(3'h6, 16'h0);
    $display("Global table test done");
    mem_u.dly = 3;
    load(3'h3, 16'h0017, 1'b0, 2'h0);
    rd(3'h3, 16'h0017);
    xref(3'h3, 32'hFFF, 3'h2, 36'h000400FFF);
    xref(3'h3, 32'h1000, 3'h4, 36'h0);
    $display("Local table test done");
    load(3'h4, 16'h0020, 1'b0, 2'h1);
    rd(3'h4, 16'h0000);
    load(3'h1, 16'h0028, 1'b0, 2'h2);
    $display("Load fault test done");
    mem_u.tbl[GB + 8] = mk(32'h00001000, 20'h00FFF, 4'h2, 1'b1, 1'b0);
    xref(3'h2, 32'h10, 3'h2, 36'h012345688);
    load(3'h2, 16'h0008, 1'b0, 2'h0);
    xref(3'h2, 32'h10, 3'h2, 36'h000001010);
    $display("Cache test done");
    mem_u.dly = 0;
    load(3'h5, 16'h0030, 1'b0, 2'h0);
    xref(3'h5, 32'hFFF, 3'h4, 36'h0);
    xref(3'h5, 32'h1000, 3'h2, 36'h000101000);
    load(3'h7, 16'h0008, 1'b0, 2'h2);
    $display("Expand-down test done");
    load(3'h2, 16'h0018, 1'b1, 2'h0);
    rd(3'h0, 16'h0018);
    REF_WRITE = 1'b1;
    xref(3'h0, 32'h0, 3'h4, 36'h0);
    $display("Implied load test done");
    PAGING_EN = 1'b1;
    REF_USER = 1'b1;
    CONTROL_REGISTER_FOUR = 32'h00000020;
    xref(3'h2, 32'h20, 3'h1, 36'h000001020);
    chk({PAGE_WIDE, PAGE_WRITE, PAGE_USER}, 3'h7);
    xref(3'h6, 32'h0, 3'h4, 36'h0);
    CONTROL_REGISTER_FOUR = 32'h0;
    {REF_WRITE, REF_USER} = 2'h0;
    xref(3'h2, 32'h24, 3'h1, 36'h000001024);
    chk({PAGE_WIDE, PAGE_WRITE, PAGE_USER}, 3'h0);
    $display("Paging test done");
    @(negedge CLK);
    CE = 1'b0;
    REF_REQ = 1'b1;
    @(negedge CLK);
    chk({REF_GP, PHYS_VALID, PAGE_VALID}, 3'h0);
    CE = 1'b1;
    REF_REQ = 1'b0;
    RESETN = 1'b0;
    @(negedge CLK);
    RESETN = 1'b1;
    rd(3'h0, 16'h0);
    xref(3'h0, 32'h0, 3'h4, 36'h0);
    $display("Freeze and reset test done");
    test_done();
  end
endmodule : segment_address_translation_tb_top
bind segment_address_translation seg_xlat_chk #(.PHYS_W(PHYS_W)) chk_u (.CLK, .RESETN, .CE,
  .LOAD_REQ, .LOAD_SEG, .LOAD_SEL, .LOAD_IMPLIED, .LOAD_BUSY, .LOAD_DONE, .LOAD_GP, .LOAD_NP,
  .DESC_REQ, .DESC_ADDR, .DESC_ACK, .GLOBAL_TABLE_BASE_REG, .LOCAL_TABLE_BASE_REG,
  .CONTROL_REGISTER_FOUR, .PAGING_EN, .REF_REQ, .REF_WRITE, .REF_USER, .REF_GP, .PHYS_VALID,
  .PHYS_ADDR, .PAGE_VALID, .PAGE_WRITE, .PAGE_USER, .PAGE_WIDE);
